// File: pwc_top.v
// Periodic wakeup counter: APB slave, source select, prescaler, counter.
`timescale 1ns/1ns
`default_nettype none
`include "pwc_defines.vh"

module pwc_top (
  // Bus clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Source clocks, sampled as levels
  input wire low_power_osc_clock,
  input wire external_ref_clock,
  input wire internal_ref_clock,
  // Debug freeze
  input wire debug_active,
  // Interrupt request
  output reg tick_irq
);

  // =====================================================================
  // Divide ratio lookup
  function [17:0] pwc_ratio;
    input src0;
    input [3:0] div;
    begin
      pwc_ratio = 18'h00001;
      if (!src0) begin
        case (div)
          4'h1: pwc_ratio = 18'h00008;
          4'h2: pwc_ratio = 18'h00020;
          4'h3: pwc_ratio = 18'h00040;
          4'h4: pwc_ratio = 18'h00080;
          4'h5: pwc_ratio = 18'h00100;
          4'h6: pwc_ratio = 18'h00200;
          4'h7: pwc_ratio = 18'h00400;
          4'h8: pwc_ratio = 18'h00001;
          4'h9: pwc_ratio = 18'h00002;
          4'ha: pwc_ratio = 18'h00004;
          4'hb: pwc_ratio = 18'h0000a;
          4'hc: pwc_ratio = 18'h00010;
          4'hd: pwc_ratio = 18'h00064;
          4'he: pwc_ratio = 18'h001f4;
          4'hf: pwc_ratio = 18'h003e8;
          default: pwc_ratio = 18'h00001;
        endcase
      end else begin
        case (div)
          4'h1: pwc_ratio = 18'h00400;
          4'h2: pwc_ratio = 18'h00800;
          4'h3: pwc_ratio = 18'h01000;
          4'h4: pwc_ratio = 18'h02000;
          4'h5: pwc_ratio = 18'h04000;
          4'h6: pwc_ratio = 18'h08000;
          4'h7: pwc_ratio = 18'h10000;
          4'h8: pwc_ratio = 18'h003e8;
          4'h9: pwc_ratio = 18'h007d0;
          4'ha: pwc_ratio = 18'h01388;
          4'hb: pwc_ratio = 18'h02710;
          4'hc: pwc_ratio = 18'h04e20;
          4'hd: pwc_ratio = 18'h0c350;
          4'he: pwc_ratio = 18'h186a0;
          4'hf: pwc_ratio = 18'h30d40;
          default: pwc_ratio = 18'h00001;
        endcase
      end
    end
  endfunction

  // =====================================================================
  // State
  reg [1:0] source_select;
  reg [3:0] divider_select;
  reg tick_irq_enable;
  reg tick_flag;
  reg [7:0] modulo_compare;
  reg [7:0] count_value;
  reg [17:0] presc;
  reg src_prev;

  reg next_tick_flag;
  reg [7:0] next_count;
  reg [17:0] next_presc;
  reg sel_clk;
  reg [17:0] ratio;
  reg restart;
  reg presc_out;

  wire access_done = psel & penable & pready;
  wire wr_done = access_done & pwrite;
  wire hit_ctrl = (paddr == `PWC_OFF_CTRL);
  wire hit_count = (paddr == `PWC_OFF_COUNT);
  wire hit_mod = (paddr == `PWC_OFF_MOD);
  wire hit_any = hit_ctrl | hit_count | hit_mod;
  wire wr_ctrl = wr_done & hit_ctrl;
  wire wr_mod = wr_done & hit_mod;
  wire [1:0] wr_src = pwdata[`PWC_SRC_HI:`PWC_SRC_LO];
  wire [3:0] wr_div = pwdata[`PWC_DIV_HI:`PWC_DIV_LO];

  // =====================================================================
  // Source mux and prescaler/counter next state
  always @* begin
    case (source_select)
      `PWC_SRC_LPO: sel_clk = low_power_osc_clock;
      `PWC_SRC_EXT: sel_clk = external_ref_clock;
      default: sel_clk = internal_ref_clock;
    endcase
    ratio = pwc_ratio(source_select[0], divider_select);
    // A modulo write or a changed selection restarts the prescaler and the counter
    restart = wr_mod
      | (wr_ctrl & (wr_src != source_select))
      | (wr_ctrl & (wr_div != divider_select));
    presc_out = 1'b0;
    next_presc = presc;
    next_count = count_value;
    next_tick_flag = tick_flag;
    // Clear first so a same-cycle tick still sets the flag
    if (wr_ctrl && pwdata[`PWC_FLAG_BIT]) begin
      next_tick_flag = 1'b0;
    end
    if (restart) begin
      next_presc = `PWC_RST_PRESC;
      next_count = `PWC_RST_COUNT;
    end else if (divider_select != 4'h0 && !debug_active) begin
      // Rising edge of selected source, sampled on pclk
      if (sel_clk && !src_prev) begin
        if (presc >= ratio - 18'h00001) begin
          next_presc = `PWC_RST_PRESC;
          presc_out = 1'b1;
        end else begin
          next_presc = presc + 18'h00001;
        end
      end
      if (presc_out) begin
        if (count_value == modulo_compare) begin
          next_count = 8'h00;
          next_tick_flag = 1'b1;
        end else begin
          next_count = count_value + 8'h01;
        end
      end
    end
  end

  // =====================================================================
  // Counting and control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_select <= `PWC_RST_SRC;
      divider_select <= `PWC_RST_DIV;
      tick_irq_enable <= 1'b0;
      tick_flag <= 1'b0;
      modulo_compare <= `PWC_RST_MOD;
      count_value <= `PWC_RST_COUNT;
      presc <= `PWC_RST_PRESC;
      src_prev <= 1'b0;
      tick_irq <= 1'b0;
    end else begin
      src_prev <= sel_clk;
      presc <= next_presc;
      count_value <= next_count;
      tick_flag <= next_tick_flag;
      tick_irq <= next_tick_flag & (wr_ctrl ? pwdata[`PWC_IE_BIT] :
                  tick_irq_enable);
      if (wr_ctrl) begin
        source_select <= wr_src;
        divider_select <= wr_div;
        tick_irq_enable <= pwdata[`PWC_IE_BIT];
      end
      if (wr_mod) begin
        modulo_compare <= pwdata[7:0];
      end
    end
  end

  // =====================================================================
  // APB answer: one wait state, then registered data and status
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit_any;
      prdata <= 32'h00000000;
      if (psel && penable && !pready && !pwrite) begin
        if (hit_ctrl) begin
          prdata <= {24'h000000, tick_flag, source_select,
                     tick_irq_enable, divider_select};
        end else if (hit_count) begin
          prdata <= {24'h000000, count_value};
        end else if (hit_mod) begin
          prdata <= {24'h000000, modulo_compare};
        end
      end
    end
  end

endmodule // pwc_top
`default_nettype wire

// File: pwc_defines.vh
// Constants for the periodic wakeup counter: offsets, fields, resets.
// =====================================================================
`ifndef PWC_DEFINES_VH
`define PWC_DEFINES_VH

// =====================================================================
// Register byte offsets
`define PWC_OFF_CTRL 12'h000
`define PWC_OFF_COUNT 12'h004
`define PWC_OFF_MOD 12'h008

// =====================================================================
// Control register fields
`define PWC_FLAG_BIT 7
`define PWC_SRC_HI 6
`define PWC_SRC_LO 5
`define PWC_IE_BIT 4
`define PWC_DIV_HI 3
`define PWC_DIV_LO 0

// =====================================================================
// Reset values
`define PWC_RST_SRC 2'h0
`define PWC_RST_DIV 4'h0
`define PWC_RST_MOD 8'h00
`define PWC_RST_COUNT 8'h00
`define PWC_RST_PRESC 18'h00000

// =====================================================================
// Source select codes
`define PWC_SRC_LPO 2'h0
`define PWC_SRC_EXT 2'h1

`endif

// File: pwc_props.sv
// Port-level assertions for the periodic wakeup counter.
`timescale 1ns/1ns
`default_nettype none
`include "pwc_defines.vh"
module pwc_props (
  // Bus clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Debug and interrupt
  input wire logic debug_active,
  input wire logic tick_irq
);
  // ===================================================================
  // Bus and interrupt properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire mapped = paddr == `PWC_OFF_CTRL || paddr == `PWC_OFF_COUNT ||
    paddr == `PWC_OFF_MOD;
  wire clr_wr = pready && pwrite && paddr == `PWC_OFF_CTRL && pwdata[7];
  a_ready_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && $past(penable))
    else $error("pready outside access phase");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata nonzero outside answer");
  a_rdata_byte_only: assert property
    (pready |-> prdata[31:8] == 24'h0)
    else $error("prdata upper bits nonzero");
  a_unmapped_zero: assert property (pready && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property
    (!$past(presetn) |-> !tick_irq && !pready)
    else $error("outputs active after reset");
  // Debug held so no tick can race the clear
  a_clear_drops_irq: assert property
    (debug_active [*3] ##0 clr_wr |-> ##2 !tick_irq)
    else $error("tick_irq stays after flag clear");
  c_err: cover property (pready && pslverr);
  c_irq: cover property ($rose(tick_irq));
  c_clear: cover property (debug_active && clr_wr);
endmodule // pwc_props
bind pwc_top pwc_props u_pwc_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .debug_active(debug_active), .tick_irq(tick_irq));
`default_nettype wire

// File: tb.sv
// Self-checking testbench for the periodic wakeup counter.
`timescale 1ns/1ns
`default_nettype none
`include "pwc_defines.vh"
module tb;
  logic pclk, presetn, psel, penable, pwrite, dbg, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdat;
  logic [2:0] src;
  wire [31:0] prdata;
  wire pready, pslverr, tick_irq;
  int fail_count = 0;
  int n_compared = 0;
  localparam logic [11:0] ctl = `PWC_OFF_CTRL;
  localparam logic [11:0] cnt = `PWC_OFF_COUNT;
  localparam logic [11:0] mdl = `PWC_OFF_MOD;
  pwc_top u_pwc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_power_osc_clock(src[0]), .external_ref_clock(src[1]),
    .internal_ref_clock(src[2]), .debug_active(dbg), .tick_irq(tick_irq));
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  // ===================================================================
  // Tasks
  task automatic chk(input logic [31:0] v, input logic [31:0] e);
    n_compared++;
    if (v !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, v, e);
    end
  endtask
  // Idle cycle at the end keeps back-to-back calls off one time step
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic pulse(input int i);
    src[i] <= 1;
    repeat (2) @(posedge pclk);
    src[i] <= 0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #(20000 * 100);
    fail_count++;
    close_out;
  end
  // ===================================================================
  // Scenarios
  initial begin
    {psel, penable, pwrite, dbg, presetn} = 0;
    paddr = 0;
    pwdata = 0;
    src = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(ctl, 0);
    rd(mdl, 0);
    xfer(0, 12'h00c, 0);
    chk(rerr, 1);
    xfer(1, mdl, 32'hff);
    rd(mdl, 32'hff);
    xfer(1, mdl, 3);
    xfer(1, cnt, 32'h55);
    rd(cnt, 0);
    pulse(0);
    rd(cnt, 0);
    xfer(1, ctl, 32'h18);
    repeat (3) pulse(0);
    rd(cnt, 3);
    rd(ctl, 32'h18);
    pulse(0);
    rd(cnt, 0);
    rd(ctl, 32'h98);
    chk(tick_irq, 1);
    xfer(1, ctl, 32'h18);
    rd(ctl, 32'h98);
    pulse(0);
    xfer(1, mdl, 3);
    rd(cnt, 0);
    dbg <= 1;
    pulse(0);
    rd(cnt, 0);
    xfer(1, ctl, 32'h98);
    rd(ctl, 32'h18);
    chk(tick_irq, 0);
    dbg <= 0;
    pulse(0);
    xfer(1, ctl, 32'h19);
    rd(cnt, 0);
    repeat (2) pulse(0);
    rd(cnt, 1);
    xfer(1, ctl, 32'h38);
    rd(cnt, 0);
    repeat (999) pulse(1);
    rd(cnt, 0);
    pulse(1);
    rd(cnt, 1);
    xfer(1, ctl, 32'h58);
    pulse(2);
    pulse(1);
    rd(cnt, 1);
    xfer(1, mdl, 0);
    pulse(2);
    rd(ctl, 32'hd8);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(ctl, 0);
    rd(cnt, 0);
    close_out;
  end
endmodule // tb
`default_nettype wire
